/* rtl/csc_map.svh */
// register map, field positions and cycle counts of the clock prescaler and sleep controller
// Behaviour
// - a new division code is taken only while the change-enable flag is set
// - the change-enable flag is set only by a write with all other bits zero
// - the change-enable flag drops four cycles after setting, or when a code is written
// - setting the flag again inside its window neither restarts nor clears it
// - division is two to the power of the code, 1 to 256; codes 9 to 15 reserved
// - the divided clock drives the whole system, so peripherals slow down too
// - reset loads code 0000, or 0011 when the divide-by-eight fuse is programmed
// - any code may be written by the protected sequence whatever the fuse holds
// - sleep is entered only if sleep enable is one when the sleep instruction runs
// - interrupt wake stalls four cycles past start-up, then the handler runs
// - register file and static memory keep their contents across sleep and wake
// - a reset during sleep wakes the device and restarts from the reset vector
// - sleep mode select sits in bits 6 and 4 of the control register
// - code 00 is idle: only cpu and flash clocks stop
// - idle wakes on external and internal peripheral interrupts
// - codes 01 and 11 are power-down: oscillator and all generated clocks stop
// - power-down wakes only on resets, serial start, level int zero or pin change
// - leaving power-down waits the restart period chosen by the clock source fuses
// - code 10 with a crystal clock is standby: power-down with oscillator running
// - standby resumes six clock cycles after the wake condition
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CSC_OFS_PRESCALE 8'h00
`define CSC_OFS_MCU_CTRL 8'h04
`define CSC_OFS_STATUS 8'h08

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSC_PCE_BIT 7
`define CSC_SM1_BIT 6
`define CSC_SE_BIT 5
`define CSC_SM0_BIT 4
`define CSC_PCE_ONLY 8'h80

// ----------------------------------------
// reset values and largest code
// ----------------------------------------
`define CSC_CODE_RST_PLAIN 4'h0
`define CSC_CODE_RST_DIV8 4'h3
`define CSC_CODE_MAX 4'h8

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define CSC_PCE_WINDOW_CYC 4
`define CSC_WAKE_HALT_CYC 4
`define CSC_STBY_RESTART_CYC 6
`define CSC_RC_RESTART_CYC 6

`endif

/* rtl/csc_pkg.sv */
// types of the clock prescaler and sleep controller
package csc_pkg;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_SLEEP = 4'h2,
		ST_RESTART = 4'h4,
		ST_HALT = 4'h8
	} state_t;

	typedef enum logic [1:0] {
		SLP_IDLE = 2'h0,
		SLP_PD = 2'h1,
		SLP_STBY = 2'h2
	} slp_mode_t;

	typedef struct packed {
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [3:0] code;
		logic pce;
		logic [1:0] pce_cnt;
		logic [1:0] sm;
		logic se;
		logic [3:0] isc;
		logic [7:0] div_cnt;
		logic tick;
		state_t state;
		slp_mode_t mode;
		logic [15:0] cnt;
		logic wake_irq;
		logic rst_vec;
		logic fuse_s1;
		logic fuse_s2;
		logic [3:0] src_s1;
		logic [3:0] src_s2;
	} regs_t;
endpackage : csc_pkg

/* rtl/clock_prescale_sleep_ctrl.sv */
// clock prescaler and sleep mode controller with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "csc_map.svh"

module clock_prescale_sleep_ctrl import csc_pkg::*; #(
	parameter logic [15:0] XTAL_RESTART_CYC = 16'd1024
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic DIVIDE_BY_EIGHT_FUSE,
	input wire logic [3:0] CLOCK_SOURCE_FUSES,
	input wire logic SLEEP_INSTR,
	input wire logic IRQ_EXTERNAL,
	input wire logic IRQ_EXTERNAL_INTERRUPT_ZERO_LEVEL,
	input wire logic IRQ_PIN_CHANGE,
	input wire logic IRQ_USI_START,
	input wire logic IRQ_PERIPH,
	input wire logic RESET_WAKE,
	output logic SYS_TICK,
	output logic CPU_CLK_EN,
	output logic FLASH_CLK_EN,
	output logic IO_CLK_EN,
	output logic OSC_EN,
	output logic SLEEPING,
	output logic WAKE_IRQ,
	output logic RESET_VECTOR
);

	// ------------------------------------------------
	// state and decode
	// ------------------------------------------------
	regs_t q;
	regs_t d;
	logic wr_go;
	logic clock_prescale_ctrl_wr;
	logic mcu_wr;
	logic wr_mapped;
	logic rd_mapped;
	logic crystal;
	logic [3:0] code_eff;
	logic [8:0] div_span;
	logic [7:0] div_top;
	logic wake_ok;
	logic [15:0] restart;
	slp_mode_t sel_mode;
	logic [31:0] rd_val;

	// both write halves in hand and no answer pending
	assign wr_go = q.aw_got && q.w_got && !q.bvalid;
	assign wr_mapped = (q.awaddr == `CSC_OFS_PRESCALE) || (q.awaddr == `CSC_OFS_MCU_CTRL);
	assign clock_prescale_ctrl_wr = wr_go && q.wstrb0 && (q.awaddr == `CSC_OFS_PRESCALE);
	assign mcu_wr = wr_go && q.wstrb0 && (q.awaddr == `CSC_OFS_MCU_CTRL);
	assign rd_mapped = (ARADDR == `CSC_OFS_PRESCALE) || (ARADDR == `CSC_OFS_MCU_CTRL)
		|| (ARADDR == `CSC_OFS_STATUS);

	// crystal options sit in the upper half of the source fuse codes
	assign crystal = q.src_s2[3];

	// reserved codes fall back to the largest factor
	assign code_eff = (q.code > `CSC_CODE_MAX) ? `CSC_CODE_MAX : q.code;
	assign div_span = 9'h1 << code_eff;
	assign div_top = 8'(div_span - 9'h1);

	// mode picked when the sleep instruction runs
	always_comb begin
		if (q.sm == 2'h0) begin
			sel_mode = SLP_IDLE;
		end else if (q.sm == 2'h2 && crystal) begin
			sel_mode = SLP_STBY;
		end else begin
			sel_mode = SLP_PD;
		end
	end

	// wake sources differ between idle and the deep modes
	always_comb begin
		if (q.mode == SLP_IDLE) begin
			wake_ok = IRQ_EXTERNAL || IRQ_EXTERNAL_INTERRUPT_ZERO_LEVEL || IRQ_PIN_CHANGE
				|| IRQ_USI_START || IRQ_PERIPH;
		end else begin
			wake_ok = IRQ_EXTERNAL_INTERRUPT_ZERO_LEVEL || IRQ_PIN_CHANGE || IRQ_USI_START;
		end
	end

	// clock restart period after the oscillator or clocks were stopped
	always_comb begin
		case (q.mode)
			SLP_IDLE: restart = 16'h0;
			SLP_STBY: restart = 16'(`CSC_STBY_RESTART_CYC);
			default: restart = crystal ? XTAL_RESTART_CYC : 16'(`CSC_RC_RESTART_CYC);
		endcase
	end

	// read multiplexer, unused bits read as zero
	always_comb begin
		case (ARADDR)
			`CSC_OFS_PRESCALE: rd_val = {24'h0, q.pce, 3'h0, q.code};
			`CSC_OFS_MCU_CTRL: rd_val = {24'h0, 1'b0, q.sm[1], q.se, q.sm[0], q.isc};
			`CSC_OFS_STATUS: rd_val = {25'h0, q.mode, q.pce, q.state};
			default: rd_val = 32'h0;
		endcase
	end

	// ------------------------------------------------
	// next state
	// ------------------------------------------------
	always_comb begin
		d = q;
		d.wake_irq = 1'b0;
		d.rst_vec = 1'b0;
		d.fuse_s1 = DIVIDE_BY_EIGHT_FUSE;
		d.fuse_s2 = q.fuse_s1;
		d.src_s1 = CLOCK_SOURCE_FUSES;
		d.src_s2 = q.src_s1;

		// write channels are taken in either order
		if (AWVALID && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.awaddr = AWADDR;
		end
		if (WVALID && !q.w_got) begin
			d.w_got = 1'b1;
			d.wdata = WDATA[7:0];
			d.wstrb0 = WSTRB[0];
		end
		if (q.bvalid && BREADY) begin
			d.bvalid = 1'b0;
		end
		if (wr_go) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wr_mapped ? 2'h0 : 2'h2;
		end

		// read answers one cycle after the address
		if (q.rvalid && RREADY) begin
			d.rvalid = 1'b0;
		end
		if (ARVALID && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata = rd_val;
			d.rresp = rd_mapped ? 2'h0 : 2'h2;
		end

		// change-enable window runs down on its own
		if (q.pce) begin
			if (q.pce_cnt == 2'h0) begin
				d.pce = 1'b0;
			end else begin
				d.pce_cnt = q.pce_cnt - 2'h1;
			end
		end

		// protected prescaler write sequence
		if (clock_prescale_ctrl_wr) begin
			if (q.wdata == `CSC_PCE_ONLY) begin
				if (!q.pce) begin
					d.pce = 1'b1;
					d.pce_cnt = 2'(`CSC_PCE_WINDOW_CYC - 1);
				end
			end else if (!q.wdata[`CSC_PCE_BIT] && q.pce) begin
				d.code = q.wdata[3:0];
				d.pce = 1'b0;
				d.div_cnt = 8'h0;
			end
		end

		// sleep control bits
		if (mcu_wr) begin
			d.sm = {q.wdata[`CSC_SM1_BIT], q.wdata[`CSC_SM0_BIT]};
			d.se = q.wdata[`CSC_SE_BIT];
			d.isc = q.wdata[3:0];
		end

		// system clock divider, tick marks each divided period
		if (!(clock_prescale_ctrl_wr && q.pce && !q.wdata[`CSC_PCE_BIT])) begin
			d.div_cnt = (q.div_cnt >= div_top) ? 8'h0 : q.div_cnt + 8'h1;
		end
		d.tick = (q.div_cnt >= div_top);

		// sleep sequencer
		case (q.state)
			ST_RUN: begin
				if (SLEEP_INSTR && q.se) begin
					d.state = ST_SLEEP;
					d.mode = sel_mode;
				end
			end
			ST_SLEEP: begin
				if (RESET_WAKE) begin
					d.state = ST_RUN;
					d.rst_vec = 1'b1;
				end else if (wake_ok) begin
					if (restart == 16'h0) begin
						d.state = ST_HALT;
						d.cnt = 16'(`CSC_WAKE_HALT_CYC - 1);
					end else begin
						d.state = ST_RESTART;
						d.cnt = restart - 16'h1;
					end
				end
			end
			ST_RESTART: begin
				if (RESET_WAKE) begin
					d.state = ST_RUN;
					d.rst_vec = 1'b1;
				end else if (q.cnt == 16'h0) begin
					d.state = ST_HALT;
					d.cnt = 16'(`CSC_WAKE_HALT_CYC - 1);
				end else begin
					d.cnt = q.cnt - 16'h1;
				end
			end
			ST_HALT: begin
				if (RESET_WAKE) begin
					d.state = ST_RUN;
					d.rst_vec = 1'b1;
				end else if (q.cnt == 16'h0) begin
					d.state = ST_RUN;
					d.wake_irq = 1'b1;
				end else begin
					d.cnt = q.cnt - 16'h1;
				end
			end
			default: begin
				d.state = ST_RUN;
			end
		endcase
	end

	// ------------------------------------------------
	// registers
	// ------------------------------------------------
	// reset needs three edges so the fuse reaches the code through its synchroniser
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			q <= '0;
			q.state <= ST_RUN;
			q.mode <= SLP_IDLE;
			q.fuse_s1 <= DIVIDE_BY_EIGHT_FUSE;
			q.fuse_s2 <= q.fuse_s1;
			q.src_s1 <= CLOCK_SOURCE_FUSES;
			q.src_s2 <= q.src_s1;
			q.code <= q.fuse_s2 ? `CSC_CODE_RST_DIV8 : `CSC_CODE_RST_PLAIN;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------
	// outputs
	// ------------------------------------------------
	assign AWREADY = !q.aw_got;
	assign WREADY = !q.w_got;
	assign BVALID = q.bvalid;
	assign BRESP = q.bresp;
	assign ARREADY = !q.rvalid;
	assign RVALID = q.rvalid;
	assign RDATA = q.rdata;
	assign RRESP = q.rresp;
	assign SYS_TICK = q.tick;

	// gating follows the sequencer; memories are never cleared, only unclocked
	assign CPU_CLK_EN = q.tick && (q.state == ST_RUN);
	assign FLASH_CLK_EN = q.tick && (q.state == ST_RUN);
	assign IO_CLK_EN = q.tick && ((q.state == ST_RUN) || (q.state == ST_HALT)
		|| (q.state == ST_SLEEP && q.mode == SLP_IDLE));
	assign OSC_EN = !(q.state == ST_SLEEP && q.mode == SLP_PD);
	assign SLEEPING = (q.state != ST_RUN);
	assign WAKE_IRQ = q.wake_irq;
	assign RESET_VECTOR = q.rst_vec;

	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	// halt entered and no reset during its four cycles
	sequence s_halt_clean;
		$rose(q.state == ST_HALT) && !RESET_WAKE ##1 (!RESET_WAKE) [*3];
	endsequence

	// standby wake with no reset during the restart count
	sequence s_stby_clean;
		q.state == ST_SLEEP && q.mode == SLP_STBY && wake_ok && !RESET_WAKE
			##1 (!RESET_WAKE) [*6];
	endsequence

	property p_code_locked;
		!q.pce && clock_prescale_ctrl_wr |=> q.code == $past(q.code);
	endproperty
	a_code_locked: assert property (p_code_locked)
		else $error("code changed without change enable");

	property p_code_taken;
		q.pce && clock_prescale_ctrl_wr && !q.wdata[7] |=> q.code == $past(q.wdata[3:0]) && !q.pce;
	endproperty
	a_code_taken: assert property (p_code_taken)
		else $error("code write inside window not taken");

	property p_pce_needs_zeros;
		!q.pce && clock_prescale_ctrl_wr && q.wdata[7] && q.wdata[6:0] != 7'h0 |=> !q.pce;
	endproperty
	a_pce_needs_zeros: assert property (p_pce_needs_zeros)
		else $error("change enable set by impure write");

	property p_pce_window;
		$rose(q.pce) |-> ##4 !q.pce;
	endproperty
	a_pce_window: assert property (p_pce_window)
		else $error("change enable window not four cycles");

	property p_pce_rewrite;
		q.pce && q.pce_cnt != 2'h0 && clock_prescale_ctrl_wr && q.wdata == 8'h80 |=> q.pce
			&& q.pce_cnt == $past(q.pce_cnt) - 2'h1;
	endproperty
	a_pce_rewrite: assert property (p_pce_rewrite)
		else $error("rewrite disturbed change enable window");

	property p_div_two;
		q.tick && q.code == 4'h1 && !clock_prescale_ctrl_wr ##1 !clock_prescale_ctrl_wr |-> !q.tick ##1 q.tick;
	endproperty
	a_div_two: assert property (p_div_two)
		else $error("divide by two period wrong");

	property p_sleep_nop;
		q.state == ST_RUN && SLEEP_INSTR && !q.se |=> q.state == ST_RUN;
	endproperty
	a_sleep_nop: assert property (p_sleep_nop)
		else $error("slept with sleep enable low");

	property p_sleep_enter;
		q.state == ST_RUN && SLEEP_INSTR && q.se |=> q.state == ST_SLEEP && !CPU_CLK_EN;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter)
		else $error("sleep not entered");

	property p_halt_four;
		s_halt_clean |-> $past(q.state, 2) == ST_HALT && $past(q.state, 1) == ST_HALT
			&& q.state == ST_HALT ##1 q.state == ST_RUN && q.wake_irq;
	endproperty
	a_halt_four: assert property (p_halt_four)
		else $error("wake halt not four cycles");

	property p_reset_wake;
		q.state == ST_SLEEP && RESET_WAKE |=> q.state == ST_RUN && q.rst_vec;
	endproperty
	a_reset_wake: assert property (p_reset_wake)
		else $error("reset did not wake to vector");

	property p_idle_clocks;
		q.state == ST_SLEEP && q.mode == SLP_IDLE |-> !CPU_CLK_EN && !FLASH_CLK_EN
			&& IO_CLK_EN == q.tick;
	endproperty
	a_idle_clocks: assert property (p_idle_clocks)
		else $error("idle gating wrong");

	property p_pd_osc;
		q.state == ST_SLEEP && q.mode == SLP_PD |-> !OSC_EN && !IO_CLK_EN;
	endproperty
	a_pd_osc: assert property (p_pd_osc)
		else $error("power-down left clocks running");

	property p_pd_deaf;
		q.state == ST_SLEEP && q.mode != SLP_IDLE && !RESET_WAKE && !IRQ_EXTERNAL_INTERRUPT_ZERO_LEVEL
			&& !IRQ_PIN_CHANGE && !IRQ_USI_START |=> q.state == ST_SLEEP;
	endproperty
	a_pd_deaf: assert property (p_pd_deaf)
		else $error("deep sleep woke on wrong source");

	property p_stby_wake;
		s_stby_clean |=> q.state == ST_HALT && $past(q.state) == ST_RESTART
			&& $past(q.state, 6) == ST_RESTART;
	endproperty
	a_stby_wake: assert property (p_stby_wake)
		else $error("standby restart not six cycles");

endmodule : clock_prescale_sleep_ctrl

/* dv/clock_prescale_sleep_ctrl_tb.sv */
// self-checking bench of the clock prescaler and sleep controller
`timescale 1ns/1ns
`include "csc_map.svh"

module clock_prescale_sleep_ctrl_tb import csc_pkg::*;;
	localparam int XTAL_CYC = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic fuse_div8 = 1'b1;
	logic [3:0] src_fuses = 4'h8;
	logic sleep_instr = 1'b0;
	logic irq_ext = 1'b0;
	logic irq_lvl0 = 1'b0;
	logic irq_pin = 1'b0;
	logic irq_usi = 1'b0;
	logic irq_per = 1'b0;
	logic rst_wake = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic sys_tick, cpu_en, flash_en, io_en, osc_en, sleeping, wake_irq, rst_vec;
	int num_errors = 0;
	int n_compared = 0;

	// ----------------------------------------
	// clock, design and closing
	// ----------------------------------------
	// 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	clock_prescale_sleep_ctrl #(.XTAL_RESTART_CYC(16'(XTAL_CYC))) u_clock_prescale_sleep_ctrl (
		.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.DIVIDE_BY_EIGHT_FUSE(fuse_div8), .CLOCK_SOURCE_FUSES(src_fuses),
		.SLEEP_INSTR(sleep_instr), .IRQ_EXTERNAL(irq_ext), .IRQ_EXTERNAL_INTERRUPT_ZERO_LEVEL(irq_lvl0),
		.IRQ_PIN_CHANGE(irq_pin), .IRQ_USI_START(irq_usi), .IRQ_PERIPH(irq_per),
		.RESET_WAKE(rst_wake), .SYS_TICK(sys_tick), .CPU_CLK_EN(cpu_en),
		.FLASH_CLK_EN(flash_en), .IO_CLK_EN(io_en), .OSC_EN(osc_en), .SLEEPING(sleeping),
		.WAKE_IRQ(wake_irq), .RESET_VECTOR(rst_vec)
	);

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	// a hang cuts the run short well past the expected length
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report();
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	// readies are looked at on the falling edge, where they equal what the next rise samples
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, b_hit;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		b_hit = 1'b0;
		while (!b_hit) begin
			@(negedge clk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid;
			if (b_hit) check_val("write resp", {30'h0, er}, {30'h0, bresp});
			@(posedge clk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
		input string what);
		logic hit;
		araddr <= a;
		arvalid <= 1'b1;
		hit = 1'b0;
		while (!hit) begin
			@(negedge clk);
			hit = arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		hit = 1'b0;
		while (!hit) begin
			@(negedge clk);
			hit = rvalid;
			if (hit) check_val(what, exp, rdata);
			if (hit) check_val("read resp", {30'h0, er}, {30'h0, rresp});
			@(posedge clk);
		end
	endtask : rd

	// cycles between two divided ticks; cpu clock gated by the same tick
	task automatic tick_period(input int exp);
		int n;
		@(negedge clk);
		while (sys_tick !== 1'b1) @(negedge clk);
		n = 1;
		@(negedge clk);
		while (sys_tick !== 1'b1) begin
			n++;
			@(negedge clk);
		end
		check_val("tick period", exp, n);
		check_val("cpu enable on tick", 32'h1, {31'h0, cpu_en});
		@(posedge clk);
	endtask : tick_period

	task automatic set_code(input logic [3:0] code);
		wr(`CSC_OFS_PRESCALE, `CSC_PCE_ONLY, 2'b00);
		wr(`CSC_OFS_PRESCALE, {4'h0, code}, 2'b00);
	endtask : set_code

	task automatic enter_sleep(input logic [7:0] ctrl);
		wr(`CSC_OFS_MCU_CTRL, ctrl, 2'b00);
		sleep_instr <= 1'b1;
		@(posedge clk);
		sleep_instr <= 1'b0;
		@(negedge clk);
	endtask : enter_sleep

	// irq order: external, level zero, pin change, serial start, peripheral
	task automatic sleep_wake(input logic [7:0] ctrl, input logic [4:0] bad,
		input logic [4:0] good, input int exp_n, input logic exp_io, input logic exp_osc);
		int n;
		enter_sleep(ctrl);
		check_val("sleeping", 32'h1, {31'h0, sleeping});
		check_val("cpu/flash gate", 32'h0, {30'h0, cpu_en, flash_en});
		check_val("io clock", {31'h0, exp_io}, {31'h0, io_en});
		check_val("oscillator", {31'h0, exp_osc}, {31'h0, osc_en});
		@(posedge clk);
		{irq_ext, irq_lvl0, irq_pin, irq_usi, irq_per} <= bad;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check_val("stays asleep", 32'h1, {31'h0, sleeping});
		@(posedge clk);
		{irq_ext, irq_lvl0, irq_pin, irq_usi, irq_per} <= good;
		@(posedge clk);
		{irq_ext, irq_lvl0, irq_pin, irq_usi, irq_per} <= 5'h00;
		n = 1;
		@(negedge clk);
		while (wake_irq !== 1'b1) begin
			@(posedge clk);
			n++;
			@(negedge clk);
		end
		check_val("wake delay", exp_n, n);
		check_val("awake", 32'h0, {31'h0, sleeping});
		@(posedge clk);
		rd(`CSC_OFS_MCU_CTRL, {24'h0, ctrl}, 2'b00, "control kept");
		wr(`CSC_OFS_MCU_CTRL, ctrl & 8'hdf, 2'b00);
	endtask : sleep_wake

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`CSC_OFS_PRESCALE, 32'h3, 2'b00, "prescale reset");
		rd(`CSC_OFS_MCU_CTRL, 32'h0, 2'b00, "control reset");
		rd(`CSC_OFS_STATUS, 32'h1, 2'b00, "status reset");
		rd(8'h0c, 32'h0, 2'b10, "unmapped read");
		wr(8'h0c, 8'hff, 2'b10);
		// a write with byte strobe zero is answered but changes nothing
		wstrb <= 4'h0;
		wr(`CSC_OFS_MCU_CTRL, 8'h20, 2'b00);
		wstrb <= 4'hf;
		rd(`CSC_OFS_MCU_CTRL, 32'h0, 2'b00, "strobe off ignored");
		tick_period(8);
		// code write without the flag open
		wr(`CSC_OFS_PRESCALE, 8'h05, 2'b00);
		rd(`CSC_OFS_PRESCALE, 32'h3, 2'b00, "code locked");
		wr(`CSC_OFS_PRESCALE, 8'h81, 2'b00);
		rd(`CSC_OFS_STATUS, 32'h1, 2'b00, "flag not set");
		wr(`CSC_OFS_PRESCALE, `CSC_PCE_ONLY, 2'b00);
		rd(`CSC_OFS_STATUS, 32'h11, 2'b00, "flag open");
		repeat (2) @(posedge clk);
		rd(`CSC_OFS_STATUS, 32'h1, 2'b00, "flag timed out");
		// a second opening write must not stretch the window
		wr(`CSC_OFS_PRESCALE, `CSC_PCE_ONLY, 2'b00);
		wr(`CSC_OFS_PRESCALE, `CSC_PCE_ONLY, 2'b00);
		wr(`CSC_OFS_PRESCALE, 8'h01, 2'b00);
		rd(`CSC_OFS_PRESCALE, 32'h3, 2'b00, "window not restarted");
		// codes 0 to 9, reserved code 9 divides as the largest factor
		for (int k = 0; k < 10; k++) begin
			set_code(4'(k));
			rd(`CSC_OFS_PRESCALE, k, 2'b00, "code taken");
			tick_period(1 << ((k > 8) ? 8 : k));
		end
		set_code(4'h0);
		enter_sleep(8'h00);
		check_val("no sleep without enable", 32'h0, {31'h0, sleeping});
		@(posedge clk);
		sleep_wake(8'h20, 5'h00, 5'h01, 1 + `CSC_WAKE_HALT_CYC, 1'b1, 1'b1);
		sleep_wake(8'h20, 5'h00, 5'h10, 1 + `CSC_WAKE_HALT_CYC, 1'b1, 1'b1);
		sleep_wake(8'h30, 5'h11, 5'h08, 1 + XTAL_CYC + `CSC_WAKE_HALT_CYC, 1'b0, 1'b0);
		sleep_wake(8'h70, 5'h11, 5'h04, 1 + XTAL_CYC + `CSC_WAKE_HALT_CYC, 1'b0, 1'b0);
		sleep_wake(8'h60, 5'h11, 5'h02, 1 + `CSC_STBY_RESTART_CYC + `CSC_WAKE_HALT_CYC, 1'b0, 1'b1);
		// reset while asleep restarts from the vector
		enter_sleep(8'h30);
		@(posedge clk);
		rst_wake <= 1'b1;
		@(posedge clk);
		rst_wake <= 1'b0;
		@(negedge clk);
		check_val("reset vector", 32'h1, {31'h0, rst_vec});
		check_val("reset wakes", 32'h0, {31'h0, sleeping});
		// second reset with the divide fuse unprogrammed
		@(posedge clk);
		rst_n <= 1'b0;
		fuse_div8 <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`CSC_OFS_PRESCALE, 32'h0, 2'b00, "prescale reset plain");
		tick_period(1);
		final_report();
	end
endmodule : clock_prescale_sleep_ctrl_tb
